// >>> design/eisf_pkg.sv
// shared constants for the two-wire eeprom front end
package eisf_pkg;
   localparam int CLK_HZ = 40000000;
   // power_up_ready_delay, in microseconds
   localparam int POWER_UP_READY_DELAY_US = 1000;
   localparam int POWER_UP_READY_CYCLES = POWER_UP_READY_DELAY_US * (CLK_HZ / 1000000);
   // glitch_filter_width, in nanoseconds
   localparam int GLITCH_FILTER_WIDTH_NS = 100;
   localparam int GLITCH_CYCLES = (GLITCH_FILTER_WIDTH_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // internal_write_cycle_time, in microseconds
   localparam int INTERNAL_WRITE_CYCLE_TIME_US = 5000;
   localparam int WRITE_CYCLE_CYCLES = INTERNAL_WRITE_CYCLE_TIME_US * (CLK_HZ / 1000000);
   // master bit timing: quarter of a 100 kHz bit
   localparam int MASTER_QUARTER_NS = 2500;
   localparam int MASTER_QUARTER_CYCLES = MASTER_QUARTER_NS * (CLK_HZ / 1000000) / 1000;
   localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;
   localparam int ADDR_TYPE_MSB = 7;
   localparam int ADDR_TYPE_LSB = 4;
   localparam int ADDR_SEL_MSB = 3;
   localparam int ADDR_SEL_LSB = 1;
   localparam int ADDR_RW_BIT = 0;
   localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
   localparam int BUF_DEPTH = 2;
endpackage : eisf_pkg

// >>> design/eisf_bus_if.sv
// two-wire bus between master and slave, with wired-and resolution
`timescale 1ns/10ps
interface eisf_bus_if;
   logic scl_m_oe;
   logic sda_m_oe;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // open drain: low whenever any party enables its driver, else pulled up
   assign scl = ~scl_m_oe;
   assign sda = ~(sda_m_oe | sda_s_oe);
   modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
   modport slave (output sda_s_oe, input scl, input sda);
endinterface : eisf_bus_if

// >>> design/eisf_slave.sv
// slave end: start/stop detection, address match, ack, write protect
`timescale 1ns/10ps
module eisf_slave (
   // clock and power-on reset
   input wire logic CLK,
   input wire logic RESET_N,
   // bus
   eisf_bus_if.slave BUS,
   // straps, low when undriven
   input wire logic [2:0] DEVICE_SELECT_PINS,
   input wire logic WRITE_PROTECT,
   // received bytes toward the array
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [7:0] RX_DATA,
   output logic RX_FIRST,
   output logic WRITE_COMMIT,
   // transmit bytes from the array
   input wire logic [7:0] TX_DATA,
   output logic TX_TAKE,
   // status
   output logic READY,
   output logic BUSY
);
   typedef enum logic [2:0] {
      EISF_IDLE = 3'b000,
      EISF_ADDR = 3'b001,
      EISF_WR = 3'b010,
      EISF_RD = 3'b011,
      EISF_IGNORE = 3'b100
   } eisf_state_t;

   logic [1:0] scl_sync_q, sda_sync_q;
   logic [1:0] wp_sync_q;
   logic scl_f_q, sda_f_q;
   logic [7:0] scl_cnt_q, sda_cnt_q;
   logic scl_prev_q, sda_prev_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   eisf_state_t state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q, tx_q;
   logic ack_q, drive_q, first_q, wp_q, protect_q, mack_q, wrote_q;
   localparam int BUF_DEPTH_L = eisf_pkg::BUF_DEPTH;
   localparam int ADDR_HI = eisf_pkg::ADDR_TYPE_MSB;
   localparam int ADDR_LO = eisf_pkg::ADDR_TYPE_LSB;
   logic [31:0] por_q, wr_q;
   logic [1:0] buf_v_q;
   logic [7:0] buf_d_q [BUF_DEPTH_L];
   logic buf_f_q [BUF_DEPTH_L];
   logic buf_in_ready;
   logic push, pop;

   function automatic logic filt_next(input logic cur, input logic raw, input logic [7:0] cnt);
      filt_next = (raw != cur && cnt >= 8'(eisf_pkg::GLITCH_CYCLES)) ? raw : cur;
   endfunction : filt_next

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         wp_sync_q <= 2'h0;
      end else begin
         scl_sync_q <= {scl_sync_q[0], BUS.scl};
         sda_sync_q <= {sda_sync_q[0], BUS.sda};
         wp_sync_q <= {wp_sync_q[0], WRITE_PROTECT};
      end
   end

   // a level must persist longer than the filter window to be accepted
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_cnt_q <= 8'h00;
         sda_cnt_q <= 8'h00;
      end else begin
         scl_cnt_q <= (scl_sync_q[1] != scl_f_q) ? scl_cnt_q + 8'h01 : 8'h00;
         sda_cnt_q <= (sda_sync_q[1] != sda_f_q) ? sda_cnt_q + 8'h01 : 8'h00;
         scl_f_q <= filt_next(scl_f_q, scl_sync_q[1], scl_cnt_q);
         sda_f_q <= filt_next(sda_f_q, sda_sync_q[1], sda_cnt_q);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_f_q;
         sda_prev_q <= sda_f_q;
      end
   end

   assign scl_rise = scl_f_q & ~scl_prev_q;
   assign scl_fall = ~scl_f_q & scl_prev_q;
   assign start_ev = scl_f_q & scl_prev_q & sda_prev_q & ~sda_f_q;
   assign stop_ev = scl_f_q & scl_prev_q & ~sda_prev_q & sda_f_q;

   // ready delay and internal write cycle counters
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         por_q <= 32'h0;
         wr_q <= 32'h0;
      end else begin
         if (por_q < 32'(eisf_pkg::POWER_UP_READY_CYCLES)) begin
            por_q <= por_q + 32'h1;
         end
         if (WRITE_COMMIT) begin
            wr_q <= 32'(eisf_pkg::WRITE_CYCLE_CYCLES);
         end else if (wr_q != 32'h0) begin
            wr_q <= wr_q - 32'h1;
         end
      end
   end
   assign READY = (por_q >= 32'(eisf_pkg::POWER_UP_READY_CYCLES));
   assign BUSY = (wr_q != 32'h0);

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= EISF_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'hFF;
         ack_q <= 1'b0;
         drive_q <= 1'b0;
         first_q <= 1'b0;
         wp_q <= 1'b0;
         protect_q <= 1'b0;
         mack_q <= 1'b0;
         wrote_q <= 1'b0;
         WRITE_COMMIT <= 1'b0;
         TX_TAKE <= 1'b0;
      end else begin
         WRITE_COMMIT <= 1'b0;
         TX_TAKE <= 1'b0;
         if (start_ev && READY) begin
            state_q <= EISF_ADDR;
            // the scl fall that closes the start wraps this to bit 0
            bit_q <= 4'hF;
            wp_q <= 1'b0;
            protect_q <= 1'b0;
            drive_q <= 1'b0;
            ack_q <= 1'b0;
            WRITE_COMMIT <= wrote_q & ~protect_q & ~BUSY;
            wrote_q <= 1'b0;
         end else if (stop_ev) begin
            state_q <= EISF_IDLE;
            drive_q <= 1'b0;
            WRITE_COMMIT <= wrote_q & ~protect_q & ~BUSY;
            wrote_q <= 1'b0;
         end else if (state_q == EISF_IDLE || state_q == EISF_IGNORE) begin
            drive_q <= 1'b0;
         end else if (scl_rise) begin
            if (bit_q == eisf_pkg::ACK_BIT_INDEX) begin
               mack_q <= ~sda_f_q;
            end else begin
               shift_q <= {shift_q[6:0], sda_f_q};
            end
         end else if (scl_fall) begin
            if (bit_q == 4'h7) begin
               case (state_q)
                  EISF_ADDR: begin
                     ack_q <= (shift_q[ADDR_HI:ADDR_LO] == eisf_pkg::DEVICE_TYPE_CODE)
                        && (shift_q[eisf_pkg::ADDR_SEL_MSB:eisf_pkg::ADDR_SEL_LSB]
                        == DEVICE_SELECT_PINS) && !BUSY;
                     drive_q <= (shift_q[ADDR_HI:ADDR_LO] == eisf_pkg::DEVICE_TYPE_CODE)
                        && (shift_q[eisf_pkg::ADDR_SEL_MSB:eisf_pkg::ADDR_SEL_LSB]
                        == DEVICE_SELECT_PINS) && !BUSY;
                     first_q <= 1'b1;
                  end
                  EISF_WR: begin
                     ack_q <= buf_in_ready && !wp_q;
                     drive_q <= buf_in_ready && !wp_q;
                  end
                  default: begin
                     drive_q <= 1'b0; // master acks, slave releases
                  end
               endcase
               bit_q <= eisf_pkg::ACK_BIT_INDEX;
            end else if (bit_q == eisf_pkg::ACK_BIT_INDEX) begin
               bit_q <= 4'h0;
               if (state_q == EISF_ADDR) begin
                  state_q <= !ack_q ? EISF_IGNORE
                     : (shift_q[eisf_pkg::ADDR_RW_BIT] ? EISF_RD : EISF_WR);
                  if (ack_q && shift_q[eisf_pkg::ADDR_RW_BIT]) begin
                     tx_q <= {TX_DATA[6:0], 1'b1};
                     drive_q <= ~TX_DATA[7];
                     TX_TAKE <= 1'b1;
                  end else begin
                     drive_q <= 1'b0;
                  end
               end else if (state_q == EISF_RD) begin
                  state_q <= mack_q ? EISF_RD : EISF_IGNORE;
                  tx_q <= {TX_DATA[6:0], 1'b1};
                  drive_q <= mack_q & ~TX_DATA[7];
                  TX_TAKE <= mack_q;
               end else begin
                  drive_q <= 1'b0;
                  if (state_q == EISF_WR && !ack_q) begin
                     state_q <= EISF_IGNORE;
                  end
                  if (state_q == EISF_WR && ack_q && first_q) begin
                     first_q <= 1'b0;
                     // protect is strobed on the last fall before the first data byte
                     wp_q <= wp_sync_q[1];
                     protect_q <= wp_sync_q[1];
                  end
               end
               ack_q <= 1'b0;
            end else begin
               if (state_q == EISF_RD) begin
                  drive_q <= ~tx_q[7];
                  tx_q <= {tx_q[6:0], 1'b1};
               end
               bit_q <= bit_q + 4'h1;
            end
         end
         // the word address alone must not start an internal write
         if (push && !first_q) begin
            wrote_q <= 1'b1;
         end
      end
   end
   assign BUS.sda_s_oe = drive_q;

   // two-entry buffer of received bytes; a stall refuses the ack
   assign buf_in_ready = (buf_v_q != 2'h2);
   assign push = scl_fall && state_q == EISF_WR && bit_q == 4'h7 && buf_in_ready
      && !wp_q && !start_ev && !stop_ev;
   assign pop = RX_VALID && RX_READY;
   assign RX_VALID = (buf_v_q != 2'h0);
   assign RX_DATA = buf_d_q[0];
   assign RX_FIRST = buf_f_q[0];

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         buf_v_q <= 2'h0;
         buf_d_q[0] <= 8'h00;
         buf_d_q[1] <= 8'h00;
         buf_f_q[0] <= 1'b0;
         buf_f_q[1] <= 1'b0;
      end else begin
         if (pop) begin
            buf_d_q[0] <= buf_d_q[1];
            buf_f_q[0] <= buf_f_q[1];
         end
         if (push) begin
            buf_d_q[(pop || buf_v_q == 2'h0) ? 0 : 1] <= shift_q;
            buf_f_q[(pop || buf_v_q == 2'h0) ? 0 : 1] <= first_q;
         end
         buf_v_q <= buf_v_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : eisf_slave

// >>> design/eisf_master.sv
// master end: generates scl, start, stop and bytes on request
`timescale 1ns/10ps
module eisf_master (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // bus
   eisf_bus_if.master BUS,
   // command: start, byte, stop flags
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_START,
   input wire logic CMD_STOP,
   input wire logic CMD_READ,
   input wire logic CMD_NACK,
   input wire logic [7:0] CMD_DATA,
   // result
   output logic RES_VALID,
   output logic [7:0] RES_DATA,
   output logic RES_ACK
);
   typedef enum logic [2:0] {
      EISFM_IDLE = 3'b000,
      EISFM_START = 3'b001,
      EISFM_BIT = 3'b010,
      EISFM_STOP = 3'b011,
      EISFM_FREE = 3'b100
   } eisfm_state_t;
   localparam logic [15:0] QTR = 16'(eisf_pkg::MASTER_QUARTER_CYCLES);

   eisfm_state_t state_q;
   logic [15:0] tick_q;
   logic [1:0] phase_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic stop_q, read_q, scl_oe_q, sda_oe_q;
   logic [1:0] sda_sync_q;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sda_sync_q <= 2'h3;
      end else begin
         sda_sync_q <= {sda_sync_q[0], BUS.sda};
      end
   end

   assign CMD_READY = (state_q == EISFM_IDLE);
   assign BUS.scl_m_oe = scl_oe_q;
   assign BUS.sda_m_oe = sda_oe_q;

   // quarter-period sequencer; phases 0..3 = low, low, high, high
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= EISFM_IDLE;
         tick_q <= 16'h0000;
         phase_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 9'h1FF;
         stop_q <= 1'b0;
         read_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         RES_VALID <= 1'b0;
         RES_DATA <= 8'h00;
         RES_ACK <= 1'b0;
      end else begin
         RES_VALID <= 1'b0;
         tick_q <= (tick_q == QTR - 16'h1) ? 16'h0000 : tick_q + 16'h1;
         case (state_q)
            EISFM_IDLE: begin
               tick_q <= 16'h0000;
               phase_q <= 2'h0;
               if (CMD_VALID) begin
                  stop_q <= CMD_STOP;
                  read_q <= CMD_READ;
                  bit_q <= 4'h0;
                  // a read byte releases sda, then acks unless last
                  sh_q <= CMD_READ ? {8'hFF, CMD_NACK} : {CMD_DATA, 1'b1};
                  state_q <= CMD_START ? EISFM_START : EISFM_BIT;
               end
            end
            EISFM_START: begin
               if (tick_q == QTR - 16'h1) begin
                  phase_q <= phase_q + 2'h1;
                  case (phase_q)
                     // scl left as found: low for a repeated start, high when idle
                     2'h0: sda_oe_q <= 1'b0;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b1;
                     default: begin
                        scl_oe_q <= 1'b1;
                        state_q <= EISFM_BIT;
                     end
                  endcase
               end
            end
            EISFM_BIT: begin
               if (tick_q == QTR - 16'h1) begin
                  phase_q <= phase_q + 2'h1;
                  case (phase_q)
                     2'h0: sda_oe_q <= ~sh_q[8];
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sh_q <= {sh_q[7:0], sda_sync_q[1]};
                     default: begin
                        scl_oe_q <= 1'b1;
                        if (bit_q == eisf_pkg::ACK_BIT_INDEX) begin
                           RES_VALID <= 1'b1;
                           RES_DATA <= sh_q[8:1];
                           RES_ACK <= ~sh_q[0];
                           state_q <= stop_q ? EISFM_STOP : EISFM_IDLE;
                        end else begin
                           bit_q <= bit_q + 4'h1;
                        end
                     end
                  endcase
               end
            end
            EISFM_STOP: begin
               if (tick_q == QTR - 16'h1) begin
                  phase_q <= phase_q + 2'h1;
                  case (phase_q)
                     2'h0: sda_oe_q <= 1'b1;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b0;
                     default: state_q <= EISFM_FREE;
                  endcase
               end
            end
            EISFM_FREE: begin
               // bus-free interval before the next start
               if (tick_q == QTR - 16'h1) begin
                  phase_q <= phase_q + 2'h1;
                  if (phase_q == 2'h3) begin
                     state_q <= EISFM_IDLE;
                  end
               end
            end
            default: state_q <= EISFM_IDLE;
         endcase
      end
   end
endmodule : eisf_master

// >>> sim/eisf_chk.sv
// bus and status assertions for the joined master and slave ends
`timescale 1ns/10ps
module eisf_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // bus wires
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda,
   // slave status
   input wire logic READY,
   input wire logic BUSY
);
   // bus-free minimum at 40 MHz
   localparam int BUS_FREE_CYCLES = 188;
   logic scl_q, sda_q, started_q, busy_q;
   logic [3:0] rise_q;
   logic [7:0] free_q;
   logic [15:0] up_q;
   logic start_w;
   logic stop_w;
   assign start_w = scl && scl_q && sda_q && !sda;
   assign stop_w = scl && scl_q && !sda_q && sda;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         started_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (start_w) started_q <= 1'b1;
         if (start_w) busy_q <= 1'b1;
         else if (stop_w) busy_q <= 1'b0;
      end
   end
   // scl rises since the last start, saturating
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) rise_q <= 4'h0;
      else if (start_w) rise_q <= 4'h0;
      else if (scl && !scl_q && rise_q != 4'hF) rise_q <= rise_q + 4'h1;
   end
   // reset counts as a long idle so the first start is legal
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) free_q <= 8'hFF;
      else if (busy_q || !(scl && sda)) free_q <= 8'h00;
      else if (free_q != 8'hFF) free_q <= free_q + 8'h01;
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) up_q <= 16'h0000;
      else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   chk_standby_reset: assert property ((up_q < 16'h0008) |-> !READY && !BUSY)
      else $error("status active right after reset");
   chk_ready_delay: assert property ((up_q == 16'(eisf_pkg::POWER_UP_READY_CYCLES + 16)) |-> READY)
      else $error("slave not ready after power-up delay");
   chk_quiet_unready: assert property (!READY |-> !sda_s_oe)
      else $error("slave drives data before ready");
   chk_drive_after_fall: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl, 2))
      else $error("slave data changed outside clock low");
   chk_busy_silent: assert property (BUSY |-> !sda_s_oe)
      else $error("slave drives data during write cycle");
   chk_start_first: assert property (sda_s_oe |-> started_q)
      else $error("slave drives data before any start");
   chk_stop_release: assert property (stop_w |-> ##1 !sda_s_oe [*8])
      else $error("slave drives data after stop");
   chk_addr_listen: assert property ((rise_q < 4'h8) |-> !sda_s_oe)
      else $error("slave drives data inside address bits");
   chk_clock_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high period too short");
   chk_start_idle: assert property (start_w && !busy_q |-> free_q >= 8'(BUS_FREE_CYCLES))
      else $error("start without bus-free interval");
   chk_master_data: assert property ($changed(sda_m_oe) && scl |-> start_w || stop_w)
      else $error("master data changed while clock high");
endmodule : eisf_chk

// >>> sim/eisf_tb_top.sv
// self-checking bench: master and slave ends joined on one bus
`timescale 1ns/10ps
module eisf_tb_top;
   logic clk, reset_n, cmd_valid, cmd_ready, res_valid, res_ack;
   logic [3:0] cmd_f;
   logic [7:0] cmd_data, res_data, rx_data, tx_data;
   logic [2:0] sel;
   logic wp, rx_ready, rx_valid, rx_first, write_commit, tx_take, ready, busy;
   logic [7:0] bad_addr [2] = '{8'hA0, 8'hBA};
   int miscompares = 0;
   int check_count = 0;
   int commits = 0;
   int takes = 0;
   int n;
   eisf_bus_if bus_if ();
   eisf_master eisf_master_i (.CLK(clk), .RESET_N(reset_n), .BUS(bus_if),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_START(cmd_f[3]),
      .CMD_STOP(cmd_f[2]), .CMD_READ(cmd_f[1]), .CMD_NACK(cmd_f[0]), .CMD_DATA(cmd_data),
      .RES_VALID(res_valid), .RES_DATA(res_data), .RES_ACK(res_ack));
   eisf_slave eisf_slave_i (.CLK(clk), .RESET_N(reset_n), .BUS(bus_if),
      .DEVICE_SELECT_PINS(sel), .WRITE_PROTECT(wp), .RX_VALID(rx_valid),
      .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_FIRST(rx_first),
      .WRITE_COMMIT(write_commit), .TX_DATA(tx_data), .TX_TAKE(tx_take),
      .READY(ready), .BUSY(busy));
   eisf_chk eisf_chk_i (.CLK(clk), .RESET_N(reset_n), .scl_m_oe(bus_if.scl_m_oe),
      .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl),
      .sda(bus_if.sda), .READY(ready), .BUSY(busy));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (write_commit === 1'b1) commits++;
      if (tx_take === 1'b1) takes++;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk
   task automatic guard(input int cnt, input int lim);
      if (cnt >= lim) begin
         $display("wrong value wait expected done seen timeout");
         miscompares++;
         end_sim();
      end
   endtask : guard
   // flags are start, stop, read, nack; ack_e of z means either answer is fine
   task automatic xfer(input logic [3:0] f, input logic [7:0] d, input logic ack_e);
      int k;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_f <= f;
      cmd_data <= d;
      k = 0;
      do begin @(negedge clk); k++; end while (cmd_ready !== 1'b1 && k < 2000);
      guard(k, 2000);
      @(posedge clk);
      cmd_valid <= 1'b0;
      k = 0;
      do begin @(negedge clk); k++; end while (res_valid !== 1'b1 && k < 6000);
      guard(k, 6000);
      if (ack_e !== 1'bz) chk("ack", {7'h00, ack_e}, {7'h00, res_ack});
      if (f[1]) chk("read data", d, res_data);
   endtask : xfer
   task automatic pop(input logic [7:0] d, input logic first);
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < 100) begin @(negedge clk); k++; end
      guard(k, 100);
      chk("rx data", d, rx_data);
      chk("rx first", {7'h00, first}, {7'h00, rx_first});
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      @(negedge clk);
   endtask : pop
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_f = 4'h0;
      cmd_data = 8'h00;
      sel = 3'h5;
      wp = 1'b0;
      rx_ready = 1'b1;
      tx_data = 8'h96;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      xfer(4'b1100, 8'hAA, 1'b0);
      chk("ready", 8'h00, {7'h00, ready});
      n = 0;
      while (ready !== 1'b1 && n < 45000) begin @(negedge clk); n++; end
      guard(n, 45000);
      xfer(4'b0100, 8'hAA, 1'b0);
      for (int i = 0; i < 2; i++) xfer(4'b1100, bad_addr[i], 1'b0);
      xfer(4'b1000, 8'hAB, 1'b1);
      xfer(4'b0111, 8'h96, 1'b0);
      chk("tx take", 8'h01, {7'h00, takes > 0});
      @(posedge clk);
      wp <= 1'b1;
      xfer(4'b1000, 8'hAA, 1'b1);
      xfer(4'b0000, 8'h3C, 1'b1);
      xfer(4'b0100, 8'h5A, 1'b0);
      @(posedge clk);
      wp <= 1'b0;
      rx_ready <= 1'b0;
      // receiver stalls so both buffer entries fill
      xfer(4'b1000, 8'hAA, 1'b1);
      chk("commits", 8'h00, 8'(commits));
      xfer(4'b0000, 8'h3C, 1'b1);
      xfer(4'b0100, 8'h5A, 1'b1);
      n = 0;
      while (busy !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
      guard(n, 2000);
      chk("commits", 8'h01, 8'(commits));
      pop(8'h3C, 1'b1);
      pop(8'h5A, 1'b0);
      chk("rx valid", 8'h00, {7'h00, rx_valid});
      xfer(4'b1100, 8'hAA, 1'b0);
      chk("busy", 8'h01, {7'h00, busy});
      end_sim();
   end
endmodule : eisf_tb_top
